// ---- bench/acs_sequencer_bench.sv ----
`timescale 1ns/1ps
module acs_sequencer_bench;
	import acs_pkg::*;
	typedef struct packed {
		logic [7:0] adr;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [12:0] obs;
	} acs_row_s;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ACS_ADDR_W-1:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [11:0] quant_data_i = 12'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, conv_power_o, sample_o, convert_o, conv_clk_tick_o, ext_channel_valid_o;
	logic [3:0] ext_channel_o;
	logic [2:0] internal_source_o;
	logic ref_supply_o, bandgap_enable_o, bandgap_oe_o, irq_o;
	logic [12:0] obs;
	logic [31:0] rdat;
	logic cv_prev = 1'b0;
	logic fall_irq = 1'b0;
	int bad_count = 0;
	int check_count = 0;
	int cyc_n = 0;
	int cnt_s = 0;
	int cnt_c = 0;
	int cnt_t = 0;
	// Register effects: {irq, power, valid, channel, source, supply ref, bandgap, bandgap drive}
	acs_row_s rows [0:13] = '{
		{8'h10, 8'h01, 8'h01, 13'h0003}, {8'h10, 8'h00, 8'h00, 13'h0000},
		{8'h00, 8'h22, 8'h22, 13'h0c80}, {8'h04, 8'h08, 8'h08, 13'h0c84},
		{8'h04, 8'hb0, 8'hb0, 13'h0c80}, {8'h00, 8'h24, 8'h24, 13'h0900},
		{8'h04, 8'h40, 8'h40, 13'h0910}, {8'h04, 8'he0, 8'he0, 13'h0900},
		{8'h00, 8'h03, 8'h03, 13'h00c0}, {8'h18, 8'hff, 8'h00, 13'h00c0},
		{8'h14, 8'h06, 8'h06, 13'h00c0}, {8'h14, 8'h07, 8'h07, 13'h10c0},
		{8'h14, 8'h03, 8'h03, 13'h00c0}, {8'h04, 8'h00, 8'h00, 13'h00c0}};

	assign obs = {irq_o, conv_power_o, ext_channel_valid_o, ext_channel_o, internal_source_o,
		ref_supply_o, bandgap_enable_o, bandgap_oe_o};

	always #2.5 clk_i = ~clk_i;

	acs_sequencer i_acs_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .quant_data_i(quant_data_i), .conv_power_o(conv_power_o), .sample_o(sample_o),
		.convert_o(convert_o), .conv_clk_tick_o(conv_clk_tick_o), .ext_channel_valid_o(ext_channel_valid_o),
		.ext_channel_o(ext_channel_o), .internal_source_o(internal_source_o), .ref_supply_o(ref_supply_o),
		.bandgap_enable_o(bandgap_enable_o), .bandgap_oe_o(bandgap_oe_o), .irq_o(irq_o));

	// Phase and tick counters, irq level seen as the conversion ends, run limit
	always @(posedge clk_i) begin
		cnt_s += (sample_o === 1'b1);
		cnt_c += (convert_o === 1'b1);
		cnt_t += (conv_clk_tick_o === 1'b1);
		if (cv_prev === 1'b1 && convert_o === 1'b0) begin
			fall_irq = irq_o;
		end
		cv_prev = convert_o;
		cyc_n++;
		if (cyc_n == 20000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, dat};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chk("ack", wb_ack_o, 1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
		logic [31:0] q;
		bus(1'b1, adr, dat, q);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [7:0] exp);
		bus(1'b0, adr, 8'h00, rdat);
		chk(nm, rdat, {24'h0, exp});
	endtask : rd_chk

	// One conversion with divider select sel and quantiser value d
	task automatic conv(input logic [2:0] sel, input logic [11:0] d);
		int s0, c0, t0, n;
		quant_data_i <= d;
		fall_irq = 1'b0;
		wr(ACS_ADDR_IRQ_CTRL, 8'h03);
		wr(ACS_ADDR_CTRL_SECOND, {5'h0, sel});
		wr(ACS_ADDR_CTRL_FIRST, 8'ha0);
		s0 = cnt_s;
		c0 = cnt_c;
		t0 = cnt_t;
		wr(ACS_ADDR_CTRL_FIRST, 8'h20);
		bus(1'b0, ACS_ADDR_CTRL_FIRST, 8'h00, rdat);
		chk("busy", rdat[6], 1);
		n = 0;
		while (rdat[6] !== 1'b0 && n < 300) begin
			bus(1'b0, ACS_ADDR_CTRL_FIRST, 8'h00, rdat);
			n++;
		end
		chk("sample", cnt_s - s0, 4 << sel);
		chk("convert", cnt_c - c0, 12 << sel);
		chk("ticks", cnt_t - t0, 16);
		chk("irq at end", fall_irq, 1);
		rd_chk("flag", ACS_ADDR_IRQ_CTRL, 8'h07);
		rd_chk("high f0", ACS_ADDR_RESULT_HIGH, d[11:4]);
		rd_chk("low f0", ACS_ADDR_RESULT_LOW, {d[3:0], 4'h0});
		wr(ACS_ADDR_CTRL_FIRST, 8'h30);
		rd_chk("high f1", ACS_ADDR_RESULT_HIGH, {4'h0, d[11:8]});
		rd_chk("low f1", ACS_ADDR_RESULT_LOW, d[7:0]);
	endtask : conv

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 6; a++) begin
			rd_chk("reset value", 8'(a * 4), 8'h00);
		end
		chk("reset outputs", obs, 0);
		foreach (rows[i]) begin
			wr(rows[i].adr, rows[i].wd);
			rd_chk("readback", rows[i].adr, rows[i].rd);
			chk("outputs", obs, rows[i].obs);
		end
		conv(3'h0, 12'habc);
		conv(3'h2, 12'h5a3);
		conv(3'h1, 12'hfff);
		// Start raised mid-conversion aborts it without a flag
		wr(ACS_ADDR_IRQ_CTRL, 8'h03);
		wr(ACS_ADDR_CTRL_FIRST, 8'ha0);
		wr(ACS_ADDR_CTRL_FIRST, 8'h20);
		wr(ACS_ADDR_CTRL_FIRST, 8'ha0);
		rd_chk("abort busy", ACS_ADDR_CTRL_FIRST, 8'ha0);
		repeat (80) @(posedge clk_i);
		rd_chk("abort flag", ACS_ADDR_IRQ_CTRL, 8'h03);
		// Start pulse with power off is ignored
		wr(ACS_ADDR_CTRL_FIRST, 8'h80);
		wr(ACS_ADDR_CTRL_FIRST, 8'h00);
		chk("power off sample", sample_o, 0);
		rd_chk("power off busy", ACS_ADDR_CTRL_FIRST, 8'h00);
		// Reset in mid-conversion clears the registers and stops the converter
		wr(ACS_ADDR_CTRL_FIRST, 8'ha0);
		wr(ACS_ADDR_CTRL_FIRST, 8'h20);
		chk("busy before reset", sample_o, 1);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("reset phase", {sample_o, convert_o}, 0);
		rd_chk("reset control", ACS_ADDR_CTRL_FIRST, 8'h00);
		rd_chk("reset irq", ACS_ADDR_IRQ_CTRL, 8'h00);
		rd_chk("reset bandgap", ACS_ADDR_BANDGAP, 8'h00);
		final_report();
	end
endmodule : acs_sequencer_bench

// ---- design/acs_pkg.sv ----
package acs_pkg;
	// Word addresses of the register file on the bus
	localparam logic [7:0] ACS_ADDR_CTRL_FIRST = 8'h00;
	localparam logic [7:0] ACS_ADDR_CTRL_SECOND = 8'h04;
	localparam logic [7:0] ACS_ADDR_RESULT_HIGH = 8'h08;
	localparam logic [7:0] ACS_ADDR_RESULT_LOW = 8'h0c;
	localparam logic [7:0] ACS_ADDR_BANDGAP = 8'h10;
	localparam logic [7:0] ACS_ADDR_IRQ_CTRL = 8'h14;
	localparam int ACS_ADDR_W = 8;

	// conv_control_first fields
	localparam int ACS_F_START = 7;
	localparam int ACS_F_BUSY = 6;
	localparam int ACS_F_POWER = 5;
	localparam int ACS_F_FORMAT = 4;
	localparam int ACS_F_CHAN_LSB = 0;
	localparam int ACS_CHAN_W = 4;
	// conv_control_second fields
	localparam int ACS_F_SRC_LSB = 5;
	localparam int ACS_SRC_W = 3;
	localparam int ACS_F_REF_LSB = 3;
	localparam int ACS_REF_W = 2;
	localparam int ACS_F_DIV_LSB = 0;
	localparam int ACS_DIV_W = 3;
	// bandgap_control and irq control fields
	localparam int ACS_F_BG_EN = 0;
	localparam int ACS_F_GIE = 0;
	localparam int ACS_F_CIE = 1;
	localparam int ACS_F_FLAG = 2;

	localparam logic [7:0] ACS_CTRL_FIRST_RST = 8'h00;
	localparam logic [7:0] ACS_CTRL_SECOND_RST = 8'h00;
	localparam logic [7:0] ACS_BANDGAP_RST = 8'h00;

	// Codes of the analog path selectors
	localparam logic [ACS_REF_W-1:0] ACS_REF_SUPPLY = 2'h1;
	localparam logic [ACS_CHAN_W-1:0] ACS_CHAN_FIRST_NONE = 4'h4;
	localparam logic [ACS_SRC_W-1:0] ACS_SRC_EXT_A = 3'h0;
	localparam logic [ACS_SRC_W-1:0] ACS_SRC_EXT_B_LO = 3'h5;

	// Converter clock periods per phase, and width of the clock divider counter
	localparam logic [3:0] ACS_SAMPLE_TICKS = 4'h4;
	localparam logic [3:0] ACS_CONVERT_TICKS = 4'hc;
	localparam int ACS_DIV_CNT_W = 7;

	typedef enum logic [1:0] {
		ACS_ST_IDLE = 2'b00,
		ACS_ST_SAMPLE = 2'b01,
		ACS_ST_CONVERT = 2'b10
	} acs_state_e;
endpackage : acs_pkg

// ---- design/acs_sequencer.sv ----
`timescale 1ns/1ps
module acs_sequencer #(
	parameter int RES_W = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [acs_pkg::ACS_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [RES_W-1:0] quant_data_i,
	output logic conv_power_o,
	output logic sample_o,
	output logic convert_o,
	output logic conv_clk_tick_o,
	output logic ext_channel_valid_o,
	output logic [acs_pkg::ACS_CHAN_W-1:0] ext_channel_o,
	output logic [acs_pkg::ACS_SRC_W-1:0] internal_source_o,
	output logic ref_supply_o,
	output logic bandgap_enable_o,
	output logic bandgap_oe_o,
	output logic irq_o
);
	import acs_pkg::*;

	if (RES_W != 12) begin : g_check
		$error("acs_sequencer supports a 12-bit result only");
	end

	function automatic logic is_external(input logic [ACS_SRC_W-1:0] src);
		is_external = (src == ACS_SRC_EXT_A) || (src >= ACS_SRC_EXT_B_LO);
	endfunction : is_external

	function automatic logic [ACS_DIV_CNT_W-1:0] div_limit(input logic [ACS_DIV_W-1:0] sel);
		div_limit = ACS_DIV_CNT_W'((8'h01 << sel) - 8'h01);
	endfunction : div_limit

	logic start_q, start_d;
	logic power_q, power_d;
	logic format_q, format_d;
	logic [ACS_CHAN_W-1:0] chan_q, chan_d;
	logic [ACS_SRC_W-1:0] src_q, src_d;
	logic [ACS_REF_W-1:0] ref_q, ref_d;
	logic [ACS_DIV_W-1:0] div_sel_q, div_sel_d;
	logic bg_en_q, bg_en_d;
	logic gie_q, gie_d;
	logic cie_q, cie_d;
	logic flag_q, flag_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [RES_W-1:0] res_q, res_d;
	acs_state_e state_q, state_d;
	logic [ACS_DIV_CNT_W-1:0] div_cnt_q, div_cnt_d;
	logic [3:0] phase_q, phase_d;
	logic tick_q, tick_d;
	logic busy;
	logic req;
	logic wr;
	logic start_fall;
	logic conv_done;
	logic [7:0] res_high;
	logic [7:0] res_low;
	logic [7:0] ctrl_first;
	logic [7:0] ctrl_second;

	assign busy = (state_q != ACS_ST_IDLE);
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign start_fall = start_q && !start_d;
	assign conv_done = (state_q == ACS_ST_CONVERT) && tick_d && (phase_q == ACS_CONVERT_TICKS - 4'h1)
		&& !start_q && power_q;

	// Format 0 puts the top 8 bits high, format 1 right-justifies
	assign res_high = format_q ? {4'h0, res_q[11:8]} : res_q[11:4];
	assign res_low = format_q ? res_q[7:0] : {res_q[3:0], 4'h0};
	assign ctrl_first = {start_q, busy, power_q, format_q, chan_q};
	assign ctrl_second = {src_q, ref_q, div_sel_q};

	// Register file and bus slave
	always_comb begin
		start_d = start_q;
		power_d = power_q;
		format_d = format_q;
		chan_d = chan_q;
		src_d = src_q;
		ref_d = ref_q;
		div_sel_d = div_sel_q;
		bg_en_d = bg_en_q;
		gie_d = gie_q;
		cie_d = cie_q;
		flag_d = flag_q;
		ack_d = req;
		rdat_d = 32'h0;
		if (wr) begin
			unique case (wb_adr_i)
				ACS_ADDR_CTRL_FIRST: begin
					start_d = wb_dat_i[ACS_F_START];
					power_d = wb_dat_i[ACS_F_POWER];
					format_d = wb_dat_i[ACS_F_FORMAT];
					chan_d = wb_dat_i[ACS_F_CHAN_LSB +: ACS_CHAN_W];
				end
				ACS_ADDR_CTRL_SECOND: begin
					src_d = wb_dat_i[ACS_F_SRC_LSB +: ACS_SRC_W];
					ref_d = wb_dat_i[ACS_F_REF_LSB +: ACS_REF_W];
					div_sel_d = wb_dat_i[ACS_F_DIV_LSB +: ACS_DIV_W];
				end
				ACS_ADDR_BANDGAP: begin
					bg_en_d = wb_dat_i[ACS_F_BG_EN];
				end
				ACS_ADDR_IRQ_CTRL: begin
					gie_d = wb_dat_i[ACS_F_GIE];
					cie_d = wb_dat_i[ACS_F_CIE];
					flag_d = wb_dat_i[ACS_F_FLAG];
				end
				default: begin
				end
			endcase
		end
		if (conv_done) begin
			flag_d = 1'b1;
		end
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				ACS_ADDR_CTRL_FIRST: rdat_d = {24'h0, ctrl_first};
				ACS_ADDR_CTRL_SECOND: rdat_d = {24'h0, ctrl_second};
				ACS_ADDR_RESULT_HIGH: rdat_d = {24'h0, res_high};
				ACS_ADDR_RESULT_LOW: rdat_d = {24'h0, res_low};
				ACS_ADDR_BANDGAP: rdat_d = {31'h0, bg_en_q};
				ACS_ADDR_IRQ_CTRL: rdat_d = {29'h0, flag_q, cie_q, gie_q};
				default: rdat_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_q <= ACS_CTRL_FIRST_RST[ACS_F_START];
			power_q <= ACS_CTRL_FIRST_RST[ACS_F_POWER];
			format_q <= ACS_CTRL_FIRST_RST[ACS_F_FORMAT];
			chan_q <= ACS_CTRL_FIRST_RST[ACS_F_CHAN_LSB +: ACS_CHAN_W];
			src_q <= ACS_CTRL_SECOND_RST[ACS_F_SRC_LSB +: ACS_SRC_W];
			ref_q <= ACS_CTRL_SECOND_RST[ACS_F_REF_LSB +: ACS_REF_W];
			div_sel_q <= ACS_CTRL_SECOND_RST[ACS_F_DIV_LSB +: ACS_DIV_W];
			bg_en_q <= ACS_BANDGAP_RST[ACS_F_BG_EN];
			gie_q <= 1'b0;
			cie_q <= 1'b0;
			flag_q <= 1'b0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			start_q <= start_d;
			power_q <= power_d;
			format_q <= format_d;
			chan_q <= chan_d;
			src_q <= src_d;
			ref_q <= ref_d;
			div_sel_q <= div_sel_d;
			bg_en_q <= bg_en_d;
			gie_q <= gie_d;
			cie_q <= cie_d;
			flag_q <= flag_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// Conversion sequencer; runs on its own so the bus never waits on it
	always_comb begin
		state_d = state_q;
		div_cnt_d = div_cnt_q;
		phase_d = phase_q;
		res_d = res_q;
		tick_d = busy && (div_cnt_q == div_limit(div_sel_q));
		if (busy) begin
			div_cnt_d = tick_d ? '0 : div_cnt_q + 7'h1;
		end
		unique case (state_q)
			ACS_ST_IDLE: begin
			end
			ACS_ST_SAMPLE: begin
				if (tick_d) begin
					phase_d = phase_q + 4'h1;
					if (phase_q == ACS_SAMPLE_TICKS - 4'h1) begin
						state_d = ACS_ST_CONVERT;
						phase_d = 4'h0;
					end
				end
			end
			ACS_ST_CONVERT: begin
				if (tick_d) begin
					phase_d = phase_q + 4'h1;
				end
				if (conv_done) begin
					state_d = ACS_ST_IDLE;
					res_d = quant_data_i;
				end
			end
			default: state_d = ACS_ST_IDLE;
		endcase
		if (start_q || !power_q) begin
			state_d = ACS_ST_IDLE;
			div_cnt_d = '0;
			phase_d = 4'h0;
		end
		// Start falling wins over the reset that start high holds
		if (start_fall && power_q) begin
			state_d = ACS_ST_SAMPLE;
			div_cnt_d = '0;
			phase_d = 4'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ACS_ST_IDLE;
			div_cnt_q <= '0;
			phase_q <= 4'h0;
			tick_q <= 1'b0;
			res_q <= '0;
		end else begin
			state_q <= state_d;
			div_cnt_q <= div_cnt_d;
			phase_q <= phase_d;
			tick_q <= tick_d;
			res_q <= res_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign conv_power_o = power_q;
	assign sample_o = (state_q == ACS_ST_SAMPLE);
	assign convert_o = (state_q == ACS_ST_CONVERT);
	assign conv_clk_tick_o = tick_q;
	assign ext_channel_valid_o = power_q && is_external(src_q) && (chan_q < ACS_CHAN_FIRST_NONE);
	assign ext_channel_o = chan_q;
	assign internal_source_o = is_external(src_q) ? ACS_SRC_EXT_A : src_q;
	assign ref_supply_o = (ref_q == ACS_REF_SUPPLY);
	assign bandgap_enable_o = bg_en_q;
	assign bandgap_oe_o = bg_en_q;
	assign irq_o = flag_q && gie_q && cie_q;

	AST_BG_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
		!bg_en_q |-> !bandgap_oe_o && !bandgap_enable_o)
		else $error("bandgap output driven while disabled");

	AST_SAMPLE_FOUR: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == ACS_ST_SAMPLE && div_sel_q == 3'h0 && !start_q && power_q && $past(state_q) == ACS_ST_IDLE)
		##1 (!start_q && power_q && div_sel_q == 3'h0)[*3] |=> (state_q == ACS_ST_CONVERT))
		else $error("sampling phase is not four converter clocks");

	AST_DIV_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick_d && busy && div_sel_q == 3'h1 && !start_q && power_q) |=> !tick_d)
		else $error("divide-by-two tick came too soon");

	AST_POWER_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		!power_q |=> !busy)
		else $error("converter kept running with power off");

	AST_EXT_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_channel_valid_o |-> is_external(src_q) && chan_q < 4'h4)
		else $error("pin connected while path must be open");

	AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o |-> gie_q && cie_q && flag_q)
		else $error("interrupt without both enables");

	AST_START_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_q && !start_fall) |=> !busy)
		else $error("converter not held reset while start is high");

	AST_FLAG_AT_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
		(busy && conv_done) |=> !busy && flag_q && res_q == $past(quant_data_i))
		else $error("flag or result missing at end of conversion");

	AST_BUSY_SAMPLE: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(busy) |-> state_q == ACS_ST_SAMPLE && phase_q == 4'h0 && $past(start_q))
		else $error("busy rose without a start falling edge");

	AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !ack_q) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single-cycle ack");

	// Converter ticks seen in the running conversion, used only by the checks below
	logic [4:0] chk_ticks_q, chk_ticks_d;
	always_comb begin
		chk_ticks_d = busy ? chk_ticks_q + {4'h0, tick_d} : 5'h0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chk_ticks_q <= 5'h0;
		end else begin
			chk_ticks_q <= chk_ticks_d;
		end
	end

	AST_SAMPLE_TICKS: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == ACS_ST_SAMPLE && state_d == ACS_ST_CONVERT)
		|-> chk_ticks_q == {1'b0, ACS_SAMPLE_TICKS} - 5'h01)
		else $error("sampling phase did not last four converter clocks");

	AST_CONV_TICKS: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_done |-> chk_ticks_q == {1'b0, ACS_SAMPLE_TICKS} + {1'b0, ACS_CONVERT_TICKS} - 5'h01)
		else $error("conversion did not last sixteen converter clocks");

	AST_DIV_FOUR: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick_d && busy && div_sel_q == 3'h2 && !start_q && power_q) |=> !tick_d [*3])
		else $error("divide-by-four tick came too soon");

	AST_NO_STALL: assert property (@(posedge clk_i) disable iff (rst_i)
		(busy && wb_cyc_i && wb_stb_i && !ack_q) |=> wb_ack_o)
		else $error("bus stalled while converting");

	AST_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		(flag_q && !(wr && wb_adr_i == ACS_ADDR_IRQ_CTRL)) |=> flag_q)
		else $error("request flag dropped without a write");

	AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!conv_done |=> $stable(res_q))
		else $error("result changed outside the end of a conversion");
endmodule : acs_sequencer
